// ==== design/motor_driver_status_regs.sv ====
// Status register bank of the motor bridge driver
`timescale 1ns/100ps
module motor_driver_status_regs
(
    input  wire logic                                   clk_sys_i,
    input  wire logic                                   rst_n_i,
    input  wire logic                                   stall_detect_i,
    input  wire logic                                   overcurrent_i,
    input  wire logic                                   overvoltage_i,
    input  wire logic                                   thermal_shutdown_i,
    input  wire logic                                   logic_supply_ok_i,
    input  wire logic                                   clear_fault_cmd_i,
    input  wire logic                                   clear_count_cmd_i,
    input  wire logic                                   ripple_pulse_i,
    input  wire logic [motor_status_pkg::CNT_W-1:0]     ripple_threshold_i,
    input  wire logic [motor_status_pkg::DATA_W-1:0]    speed_estimate_i,
    input  wire logic [motor_status_pkg::DATA_W-1:0]    motor_voltage_value_i,
    input  wire logic [motor_status_pkg::DATA_W-1:0]    motor_current_value_i,
    input  wire logic [motor_status_pkg::DUTY_W-1:0]    bridge_duty_i,
    input  wire logic                                   rd_en_i,
    input  wire logic                                   wr_en_i,
    input  wire logic [motor_status_pkg::ADDR_W-1:0]    addr_i,
    input  wire logic [motor_status_pkg::DATA_W-1:0]    wdata_i,
    output logic      [motor_status_pkg::DATA_W-1:0]    rdata_o,
    output logic                                        rvalid_o,
    output logic                                        fault_out_n_o,
    output logic                                        fault_out_n_oe_o,
    output logic                                        count_done_flag_o
);
    // Fault and latch state
    logic                                 overcurrent_flag_ff;
    logic                                 overvoltage_flag_ff;
    logic                                 thermal_shutdown_flag_ff;
    logic                                 stall_flag_ff;
    logic                                 fault_summary_ff;
    logic                                 power_on_indicator_ff;
    logic                                 count_done_flag_ff;
    logic                                 fault_pin_oe_ff;
    logic                                 fault_level_ff;
    logic                                 nxt_overcurrent_flag;
    logic                                 nxt_overvoltage_flag;
    logic                                 nxt_thermal_shutdown_flag;
    logic                                 nxt_stall_flag;
    logic                                 nxt_fault_summary;
    logic                                 nxt_power_on_indicator;
    logic                                 nxt_count_done_flag;
    logic                                 nxt_fault_pin_oe;
    logic                                 nxt_fault_level;

    // Ripple counter
    logic [motor_status_pkg::CNT_W-1:0]   ripple_total_ff;
    logic [motor_status_pkg::CNT_W-1:0]   nxt_ripple_total;

    // Read port
    logic [motor_status_pkg::DATA_W-1:0]  rdata_ff;
    logic                                 rvalid_ff;
    logic [motor_status_pkg::DATA_W-1:0]  nxt_rdata;
    logic                                 nxt_rvalid;

    // Sampled analog readouts
    logic [motor_status_pkg::DATA_W-1:0]  speed_q;
    logic [motor_status_pkg::DATA_W-1:0]  voltage_q;
    logic [motor_status_pkg::DATA_W-1:0]  current_q;
    logic [motor_status_pkg::DATA_W-1:0]  duty_q;
    logic [motor_status_pkg::DATA_W-1:0]  duty_byte;
    logic [motor_status_pkg::DATA_W-1:0]  fault_byte;

    assign duty_byte = {motor_status_pkg::RESERVED_DUTY, bridge_duty_i};

    status_byte_reg u_speed
    (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .value_i   (speed_estimate_i),
        .value_o   (speed_q)
    );

    // Codes pass through unscaled; linear scaling lives in the analog front end
    status_byte_reg u_voltage
    (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .value_i   (motor_voltage_value_i),
        .value_o   (voltage_q)
    );

    status_byte_reg u_current
    (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .value_i   (motor_current_value_i),
        .value_o   (current_q)
    );

    status_byte_reg u_duty
    (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .value_i   (duty_byte),
        .value_o   (duty_q)
    );

    // Fault flags are live levels, not sticky; summary follows in the same cycle
    always_comb
    begin
        nxt_stall_flag = stall_detect_i;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            stall_flag_ff <= 1'b0;
        end
        else
        begin
            stall_flag_ff <= nxt_stall_flag;
        end
    end

    always_comb
    begin
        nxt_overcurrent_flag = overcurrent_i;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            overcurrent_flag_ff <= 1'b0;
        end
        else
        begin
            overcurrent_flag_ff <= nxt_overcurrent_flag;
        end
    end

    always_comb
    begin
        nxt_overvoltage_flag = overvoltage_i;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            overvoltage_flag_ff <= 1'b0;
        end
        else
        begin
            overvoltage_flag_ff <= nxt_overvoltage_flag;
        end
    end

    always_comb
    begin
        nxt_thermal_shutdown_flag = thermal_shutdown_i;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            thermal_shutdown_flag_ff <= 1'b0;
        end
        else
        begin
            thermal_shutdown_flag_ff <= nxt_thermal_shutdown_flag;
        end
    end

    // Summary built from the inputs, not the flags, so it never lags them
    always_comb
    begin
        nxt_fault_summary = stall_detect_i | overcurrent_i
                          | overvoltage_i | thermal_shutdown_i;
        nxt_fault_pin_oe  = nxt_fault_summary;
        nxt_fault_level   = 1'b0;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            fault_summary_ff <= 1'b0;
            fault_pin_oe_ff  <= 1'b0;
            fault_level_ff   <= 1'b0;
        end
        else
        begin
            fault_summary_ff <= nxt_fault_summary;
            fault_pin_oe_ff  <= nxt_fault_pin_oe;
            fault_level_ff   <= nxt_fault_level;
        end
    end

    // Supply loss wins over a clear-fault arriving in the same cycle
    always_comb
    begin
        nxt_power_on_indicator = power_on_indicator_ff;
        if (!logic_supply_ok_i)
        begin
            nxt_power_on_indicator = 1'b0;
        end
        else if (clear_fault_cmd_i)
        begin
            nxt_power_on_indicator = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            power_on_indicator_ff <= 1'b0;
        end
        else
        begin
            power_on_indicator_ff <= nxt_power_on_indicator;
        end
    end

    // Ripple count and done flag; a pulse in the clear cycle is dropped with the count
    always_comb
    begin
        nxt_ripple_total    = ripple_total_ff;
        nxt_count_done_flag = count_done_flag_ff;
        if (clear_count_cmd_i)
        begin
            nxt_ripple_total    = motor_status_pkg::COUNT_RESET;
            nxt_count_done_flag = 1'b0;
        end
        else
        begin
            if (ripple_pulse_i)
            begin
                nxt_ripple_total = ripple_total_ff + motor_status_pkg::COUNT_STEP;
            end
            if (ripple_total_ff > ripple_threshold_i)
            begin
                nxt_count_done_flag = 1'b1;
            end
        end
    end

    always_comb
    begin
        fault_byte = motor_status_pkg::STATUS_RESET;
        fault_byte[motor_status_pkg::BIT_FAULT_SUMMARY] = fault_summary_ff;
        fault_byte[motor_status_pkg::BIT_RESERVED]      = 1'b0;
        fault_byte[motor_status_pkg::BIT_STALL]         = stall_flag_ff;
        fault_byte[motor_status_pkg::BIT_OVERCURRENT]   = overcurrent_flag_ff;
        fault_byte[motor_status_pkg::BIT_OVERVOLTAGE]   = overvoltage_flag_ff;
        fault_byte[motor_status_pkg::BIT_THERMAL]       = thermal_shutdown_flag_ff;
        fault_byte[motor_status_pkg::BIT_POWER_ON]      = power_on_indicator_ff;
        fault_byte[motor_status_pkg::BIT_COUNT_DONE]    = count_done_flag_ff;
    end

    // Writes are not decoded; wr_en_i only masks a read in the same cycle, so writes cannot disturb any state
    always_comb
    begin
        nxt_rvalid = rd_en_i & ~wr_en_i;
        nxt_rdata  = rdata_ff;
        if (nxt_rvalid)
        begin
            unique case (addr_i)
                motor_status_pkg::OFS_FAULT_STATUS:    nxt_rdata = fault_byte;
                motor_status_pkg::OFS_SPEED_ESTIMATE:  nxt_rdata = speed_q;
                motor_status_pkg::OFS_COUNT_LOW:       nxt_rdata = ripple_total_ff[motor_status_pkg::DATA_W-1:0];
                motor_status_pkg::OFS_COUNT_HIGH:      nxt_rdata = ripple_total_ff[motor_status_pkg::CNT_W-1:
                                                                    motor_status_pkg::DATA_W];
                motor_status_pkg::OFS_VOLTAGE_READOUT: nxt_rdata = voltage_q;
                motor_status_pkg::OFS_CURRENT_READOUT: nxt_rdata = current_q;
                motor_status_pkg::OFS_DUTY_READOUT:    nxt_rdata = duty_q;
                default:                               nxt_rdata = motor_status_pkg::UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            count_done_flag_ff <= 1'b0;
            ripple_total_ff    <= motor_status_pkg::COUNT_RESET;
        end
        else
        begin
            count_done_flag_ff <= nxt_count_done_flag;
            ripple_total_ff    <= nxt_ripple_total;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            rdata_ff  <= motor_status_pkg::STATUS_RESET;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // Open drain: level held low in a flop, only the enable moves
    assign fault_out_n_o     = fault_level_ff;
    assign fault_out_n_oe_o  = fault_pin_oe_ff;
    assign rdata_o           = rdata_ff;
    assign rvalid_o          = rvalid_ff;
    assign count_done_flag_o = count_done_flag_ff;
endmodule

// ==== design/motor_status_pkg.sv ====
// Constants for the motor driver status register bank
package motor_status_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CNT_W  = 16;
    localparam int unsigned DUTY_W = 6;

    localparam logic [ADDR_W-1:0] OFS_FAULT_STATUS    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_SPEED_ESTIMATE  = 8'h01;
    localparam logic [ADDR_W-1:0] OFS_COUNT_LOW       = 8'h02;
    localparam logic [ADDR_W-1:0] OFS_COUNT_HIGH      = 8'h03;
    localparam logic [ADDR_W-1:0] OFS_VOLTAGE_READOUT = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CURRENT_READOUT = 8'h05;
    localparam logic [ADDR_W-1:0] OFS_DUTY_READOUT    = 8'h06;

    localparam int unsigned BIT_FAULT_SUMMARY = 7;
    localparam int unsigned BIT_RESERVED      = 6;
    localparam int unsigned BIT_STALL         = 5;
    localparam int unsigned BIT_OVERCURRENT   = 4;
    localparam int unsigned BIT_OVERVOLTAGE   = 3;
    localparam int unsigned BIT_THERMAL       = 2;
    localparam int unsigned BIT_POWER_ON      = 1;
    localparam int unsigned BIT_COUNT_DONE    = 0;

    localparam logic [DATA_W-1:0] STATUS_RESET   = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_READ  = 8'h00;
    localparam logic [CNT_W-1:0]  COUNT_RESET    = 16'h0000;
    localparam logic [CNT_W-1:0]  COUNT_STEP     = 16'h0001;
    localparam logic [1:0]        RESERVED_DUTY  = 2'h0;
endpackage

// ==== design/status_byte_reg.sv ====
// One read-only status byte that follows its source
`timescale 1ns/100ps
module status_byte_reg
(
    input  wire logic                                   clk_sys_i,
    input  wire logic                                   rst_n_i,
    input  wire logic [motor_status_pkg::DATA_W-1:0]    value_i,
    output logic      [motor_status_pkg::DATA_W-1:0]    value_o
);
    logic [motor_status_pkg::DATA_W-1:0] value_ff;
    logic [motor_status_pkg::DATA_W-1:0] nxt_value;

    always_comb
    begin
        nxt_value = value_i;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            value_ff <= motor_status_pkg::STATUS_RESET;
        end
        else
        begin
            value_ff <= nxt_value;
        end
    end

    assign value_o = value_ff;
endmodule

// ==== verif/status_host.sv ====
// Host model that reads and writes the status registers
`timescale 1ns/100ps
module status_host
(
    input  wire logic       clk_sys_i,
    input  wire logic       rvalid_i,
    input  wire logic [7:0] rdata_i,
    output logic            rd_en_o,
    output logic            wr_en_o,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o
);
    initial {rd_en_o, wr_en_o, addr_o, wdata_o} = 18'h0;
    // One access; released lines show inverted data so stale values never match
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] wd,
        output logic [7:0] d, output logic v);
        @(posedge clk_sys_i);
        #1;
        {rd_en_o, wr_en_o, addr_o, wdata_o} = {~w, w, a, wd};
        @(posedge clk_sys_i);
        #1;
        {rd_en_o, wr_en_o, addr_o, wdata_o} = {2'h0, ~a, ~wd};
        v = rvalid_i;
        d = rdata_i;
    endtask
    // No snapshot of the count: re-read until the high byte agrees
    task automatic rd_cnt(output logic [15:0] c);
        logic [7:0] hi;
        logic       v;
        do
        begin
            acc(1'b0, 8'h03, 8'h00, hi, v);
            acc(1'b0, 8'h02, 8'h00, c[7:0], v);
            acc(1'b0, 8'h03, 8'h00, c[15:8], v);
        end
        while (hi !== c[15:8]);
    endtask
endmodule

// ==== verif/status_regs_monitor.sv ====
// Port-level assertion checker for the status register bank
`timescale 1ns/100ps
module status_regs_monitor
(
    input wire logic       clk_sys_i,
    input wire logic       rst_n_i,
    input wire logic       stall_detect_i,
    input wire logic       overcurrent_i,
    input wire logic       overvoltage_i,
    input wire logic       thermal_shutdown_i,
    input wire logic       clear_count_cmd_i,
    input wire logic [5:0] bridge_duty_i,
    input wire logic       wr_en_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] rdata_o,
    input wire logic       rvalid_o,
    input wire logic       fault_out_n_o,
    input wire logic       fault_out_n_oe_o,
    input wire logic       count_done_flag_o
);
    logic any_fault;
    assign any_fault = stall_detect_i | overcurrent_i | overvoltage_i | thermal_shutdown_i;
    default clocking dc @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    // Past-reset guards keep the first edges after release quiet
    a_summary_pin: assert property ($past(rst_n_i) |-> fault_out_n_oe_o == $past(any_fault))
        else $error("fault pin enable not tracking faults");
    a_pin_level: assert property (fault_out_n_oe_o |-> !fault_out_n_o)
        else $error("fault pin not pulled low");
    a_duty_read: assert property (rvalid_o && $past(addr_i) == 8'h06 && $past(rst_n_i, 2)
        |-> rdata_o == {2'h0, $past(bridge_duty_i, 2)})
        else $error("duty readout wrong");
    a_clear_done: assert property (clear_count_cmd_i |=> !count_done_flag_o)
        else $error("count done not cleared");
    a_done_hold: assert property (count_done_flag_o && !clear_count_cmd_i |=> count_done_flag_o)
        else $error("count done dropped");
    a_done_rise: assert property ($rose(count_done_flag_o) |-> !$past(clear_count_cmd_i))
        else $error("count done set during clear");
    a_write_quiet: assert property (wr_en_i |=> !rvalid_o)
        else $error("write answered");
    a_rdata_hold: assert property ($past(rst_n_i) && !rvalid_o |-> $stable(rdata_o))
        else $error("read data moved without a read");
endmodule
bind motor_driver_status_regs status_regs_monitor chk (.clk_sys_i, .rst_n_i, .stall_detect_i, .overcurrent_i,
    .overvoltage_i, .thermal_shutdown_i, .clear_count_cmd_i, .bridge_duty_i, .wr_en_i, .addr_i, .rdata_o,
    .rvalid_o, .fault_out_n_o, .fault_out_n_oe_o, .count_done_flag_o);

// ==== verif/test_motor_driver_status_regs.sv ====
// Self-checking bench for the motor status register bank
`timescale 1ns/100ps
module test_motor_driver_status_regs;
    logic           clk_sys_i, rst_n_i, stall_detect_i, overcurrent_i, overvoltage_i, thermal_shutdown_i;
    logic           logic_supply_ok_i, clear_fault_cmd_i, clear_count_cmd_i, ripple_pulse_i, v;
    logic [15:0]    ripple_threshold_i, cnt;
    logic [7:0]     speed_estimate_i, motor_voltage_value_i, motor_current_value_i, d;
    logic [5:0]     bridge_duty_i;
    wire logic      rd_en_i, wr_en_i, rvalid_o, fault_out_n_o, fault_out_n_oe_o, count_done_flag_o;
    wire logic[7:0] addr_i, wdata_i, rdata_o;
    int             n_fail = 0;
    int             checks = 0;
    motor_driver_status_regs dut (.clk_sys_i, .rst_n_i, .stall_detect_i, .overcurrent_i, .overvoltage_i,
        .thermal_shutdown_i, .logic_supply_ok_i, .clear_fault_cmd_i, .clear_count_cmd_i, .ripple_pulse_i,
        .ripple_threshold_i, .speed_estimate_i, .motor_voltage_value_i, .motor_current_value_i,
        .bridge_duty_i, .rd_en_i, .wr_en_i, .addr_i, .wdata_i, .rdata_o, .rvalid_o, .fault_out_n_o,
        .fault_out_n_oe_o, .count_done_flag_o);
    status_host host (.clk_sys_i, .rvalid_i(rvalid_o), .rdata_i(rdata_o), .rd_en_o(rd_en_i),
        .wr_en_o(wr_en_i), .addr_o(addr_i), .wdata_o(wdata_i));
    initial
    begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    task automatic complete_run;
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e)
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        n_fail += int'(g !== e);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.acc(1'b0, a, 8'h00, d, v);
        cmp({7'h0, v}, 8'h01);
        cmp(d, e);
    endtask
    // Commands and ripples for n cycles, then one idle edge so latched bits settle
    task automatic drive(input logic [2:0] c, input int n);
        @(posedge clk_sys_i);
        #1;
        {clear_fault_cmd_i, clear_count_cmd_i, ripple_pulse_i} = c;
        repeat (n) @(posedge clk_sys_i);
        #1;
        {clear_fault_cmd_i, clear_count_cmd_i, ripple_pulse_i} = 3'h0;
        @(posedge clk_sys_i);
    endtask
    initial
    begin
        repeat (3000) @(posedge clk_sys_i);
        n_fail++;
        complete_run();
    end
    initial
    begin
        {stall_detect_i, overcurrent_i, overvoltage_i, thermal_shutdown_i, logic_supply_ok_i} = 5'h00;
        {clear_fault_cmd_i, clear_count_cmd_i, ripple_pulse_i, rst_n_i} = 4'h0;
        ripple_threshold_i = 16'h0003;
        {speed_estimate_i, motor_voltage_value_i, motor_current_value_i, bridge_duty_i} = 30'h0;
        repeat (20) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        for (int a = 0; a < 8; a++)
            rchk(a[7:0], 8'h00);
        {speed_estimate_i, motor_voltage_value_i, motor_current_value_i, bridge_duty_i} = {24'h5ab0c0, 6'h3f};
        for (int a = 0; a < 7; a++)
        begin
            host.acc(1'b1, a[7:0], 8'hff, d, v);
            cmp({7'h0, v}, 8'h00);
        end
        rchk(8'h01, 8'h5a);
        rchk(8'h04, 8'hb0);
        rchk(8'h05, 8'hc0);
        rchk(8'h06, 8'h3f);
        for (int i = 0; i < 4; i++)
        begin
            {stall_detect_i, overcurrent_i, overvoltage_i, thermal_shutdown_i} = 4'h8 >> i;
            rchk(8'h00, 8'h80 | (8'h20 >> i));
            cmp({7'h0, fault_out_n_oe_o}, 8'h01);
            cmp({7'h0, fault_out_n_o}, 8'h00);
        end
        {stall_detect_i, overcurrent_i, overvoltage_i, thermal_shutdown_i} = 4'h0;
        rchk(8'h00, 8'h00);
        cmp({7'h0, fault_out_n_oe_o}, 8'h00);
        logic_supply_ok_i = 1'b1;
        rchk(8'h00, 8'h00);
        drive(3'h4, 1);
        rchk(8'h00, 8'h02);
        logic_supply_ok_i = 1'b0;
        drive(3'h0, 1);
        rchk(8'h00, 8'h00);
        drive(3'h1, 3);
        host.rd_cnt(cnt);
        cmp(cnt[7:0], 8'h03);
        host.acc(1'b1, 8'h02, 8'hff, d, v);
        host.acc(1'b1, 8'h03, 8'hff, d, v);
        host.rd_cnt(cnt);
        cmp(cnt[15:8], 8'h00);
        cmp(cnt[7:0], 8'h03);
        rchk(8'h00, 8'h00);
        drive(3'h1, 253);
        rchk(8'h00, 8'h01);
        cmp({7'h0, count_done_flag_o}, 8'h01);
        host.rd_cnt(cnt);
        cmp(cnt[15:8], 8'h01);
        cmp(cnt[7:0], 8'h00);
        // Clear and a ripple together: the clear must win
        drive(3'h3, 1);
        rchk(8'h00, 8'h00);
        host.rd_cnt(cnt);
        cmp(cnt[7:0] | cnt[15:8], 8'h00);
        cmp({7'h0, count_done_flag_o}, 8'h00);
        // Mid-run reset with count, done flag and power-on bit all set
        logic_supply_ok_i = 1'b1;
        drive(3'h5, 5);
        rchk(8'h00, 8'h03);
        cmp({7'h0, count_done_flag_o}, 8'h01);
        rst_n_i = 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1;
        rst_n_i = 1'b1;
        cmp(rdata_o, 8'h00);
        cmp({7'h0, count_done_flag_o}, 8'h00);
        rchk(8'h00, 8'h00);
        host.rd_cnt(cnt);
        cmp(cnt[7:0] | cnt[15:8], 8'h00);
        complete_run();
    end
endmodule
